// ---- shared/ipl_defs.svh ----
// Purpose: Offsets, field masks, reset values and sizes of the priority-level block.
// Assumes: 32-bit Wishbone data, word index = byte address divided by four.
// Notes: Definitions only.
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IPL_IDX_PRIO0 6'h00
`define IPL_IDX_PRIO1 6'h01
`define IPL_IDX_PRIO2 6'h02
`define IPL_IDX_PRIO3 6'h03
`define IPL_IDX_PRIO4 6'h04
`define IPL_IDX_VBASE 6'h07
`define IPL_IDX_STATUS 6'h16

// ****************************************************************
// Writable masks and reset values
// ****************************************************************
`define IPL_MASK_PRIO0 16'h03ff
`define IPL_MASK_PRIO1 16'hc03f
`define IPL_MASK_PRIO2 16'hc3ff
`define IPL_MASK_PRIO3 16'hc03f
`define IPL_MASK_PRIO4 16'hffff
`define IPL_MASK_VBASE 16'h01ff
`define IPL_RESET_PRIO 16'h0000
`define IPL_RESET_VBASE 9'h000

// ****************************************************************
// Sizes
// ****************************************************************
`define IPL_NUM_SRC 27
`define IPL_NUM_DBG 5
`define IPL_VEC_W 7
`define IPL_VBASE_W 9
`define IPL_NUM_PRIO 5

`endif

// ---- shared/ipl_pkg.sv ----
// Purpose: Types shared by the priority-level block and its bench.
// Assumes: ipl_defs.svh supplies the sizes.
// Notes: Bus signals travel as packed structs.
`include "ipl_defs.svh"

package ipl_pkg;

    // ****************************************************************
    // Bus carriers
    // ****************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } ipl_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ipl_wb_rsp_s;

    // ****************************************************************
    // Decoded level and block state
    // ****************************************************************
    typedef struct packed {
        logic en;
        logic [1:0] lvl;
    } ipl_level_s;

    typedef struct packed {
        logic [`IPL_NUM_PRIO-1:0][15:0] prio;
        logic [`IPL_VBASE_W-1:0] vbase;
        logic ack;
        logic [31:0] rdata;
        logic core_irq;
        logic [1:0] level_code;
        logic [15:0] vector;
        logic wake;
        logic lp_prev;
        logic [`IPL_NUM_SRC-1:0] lp_snap;
    } ipl_state_s;

endpackage : ipl_pkg

// ---- src/ipl_ctrl.sv ----
// Purpose: Priority-level registers, level decode, arbitration and wake request of the interrupt controller.
// Assumes: Request inputs and the low-power flag are synchronous to clk_i and held while pending.
// Notes: Answers every Wishbone access one cycle after the request; the result is one cycle behind the inputs.
//
// Decided for this implementation: the Wishbone slave port.
`include "ipl_defs.svh"

module ipl_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input ipl_pkg::ipl_wb_req_s wb_req_i,
    output ipl_pkg::ipl_wb_rsp_s wb_rsp_o,
    input wire logic [`IPL_NUM_SRC-1:0] irq_req_i,
    input wire logic low_power_i,
    output logic core_irq_o,
    output logic [1:0] level_code_o,
    output logic [15:0] vector_o,
    output logic wake_o
);
    import ipl_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic ipl_level_s decode_level(input logic [1:0] code, input logic dbg);
        ipl_level_s r;
        r.en = (code != 2'b00);
        r.lvl = dbg ? code : 2'(code - 2'b01);
        return r;
    endfunction : decode_level

    function automatic logic [15:0] merge_write(input logic [15:0] old, input logic [31:0] dat,
                                                input logic [3:0] sel, input logic [15:0] mask);
        logic [15:0] bytes;
        bytes = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
        return bytes & mask;
    endfunction : merge_write

    ipl_state_s st;
    ipl_state_s next_st;

    // ****************************************************************
    // Field map: source index to 2-bit code
    // ****************************************************************
    // Index 0..4 are the debug sources, which start at level 1; all others start at level 0.
    logic [2*`IPL_NUM_SRC-1:0] codes;
    assign codes = {st.prio[4],
                    st.prio[3][15:14], st.prio[3][5:0],
                    st.prio[2][15:14], st.prio[2][9:0],
                    st.prio[1][15:14], st.prio[1][5:0],
                    st.prio[0][9:0]};

    ipl_level_s [`IPL_NUM_SRC-1:0] src;
    genvar gi;
    generate
        for (gi = 0; gi < `IPL_NUM_SRC; gi++)
        begin : g_dec
            assign src[gi] = decode_level(codes[2*gi +: 2], gi < `IPL_NUM_DBG);
        end
    endgenerate

    logic [`IPL_NUM_SRC-1:0] src_en;
    always_comb
    begin
        for (int i = 0; i < `IPL_NUM_SRC; i++)
        begin
            src_en[i] = src[i].en;
        end
    end

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic found;
    logic [1:0] best_lvl;
    logic [`IPL_VEC_W-1:0] best_vec;
    always_comb
    begin
        found = 1'b0;
        best_lvl = 2'b00;
        best_vec = '0;
        // Scanning downward with >= lets the lower vector number win a tie.
        for (int i = `IPL_NUM_SRC - 1; i >= 0; i--)
        begin
            if (irq_req_i[i] && src[i].en && (!found || src[i].lvl >= best_lvl))
            begin
                found = 1'b1;
                best_lvl = src[i].lvl;
                best_vec = `IPL_VEC_W'(i);
            end
        end
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic bus_req;
    logic bus_wr;
    logic [5:0] idx;
    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !st.ack;
    assign bus_wr = bus_req && wb_req_i.we;
    assign idx = wb_req_i.adr[7:2];

    logic [15:0] vbase_wr;
    assign vbase_wr = merge_write({7'h00, st.vbase}, wb_req_i.dat, wb_req_i.sel, `IPL_MASK_VBASE);

    logic [15:0] rd_word;
    always_comb
    begin
        case (idx)
            `IPL_IDX_PRIO0: rd_word = st.prio[0];
            `IPL_IDX_PRIO1: rd_word = st.prio[1];
            `IPL_IDX_PRIO2: rd_word = st.prio[2];
            `IPL_IDX_PRIO3: rd_word = st.prio[3];
            `IPL_IDX_PRIO4: rd_word = st.prio[4];
            `IPL_IDX_VBASE: rd_word = {7'h00, st.vbase};
            `IPL_IDX_STATUS: rd_word = {5'h00, st.vector[6:0], 1'b0, st.core_irq, st.level_code};
            default: rd_word = 16'h0000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        next_st.ack = bus_req;
        next_st.rdata = bus_req ? {16'h0000, rd_word} : 32'h0000_0000;
        if (bus_wr)
        begin
            // Reserved bits are masked off, so a careless write cannot enable anything.
            case (idx)
                `IPL_IDX_PRIO0: next_st.prio[0] = merge_write(st.prio[0], wb_req_i.dat, wb_req_i.sel,
                                                              `IPL_MASK_PRIO0);
                `IPL_IDX_PRIO1: next_st.prio[1] = merge_write(st.prio[1], wb_req_i.dat, wb_req_i.sel,
                                                              `IPL_MASK_PRIO1);
                `IPL_IDX_PRIO2: next_st.prio[2] = merge_write(st.prio[2], wb_req_i.dat, wb_req_i.sel,
                                                              `IPL_MASK_PRIO2);
                `IPL_IDX_PRIO3: next_st.prio[3] = merge_write(st.prio[3], wb_req_i.dat, wb_req_i.sel,
                                                              `IPL_MASK_PRIO3);
                `IPL_IDX_PRIO4: next_st.prio[4] = merge_write(st.prio[4], wb_req_i.dat, wb_req_i.sel,
                                                              `IPL_MASK_PRIO4);
                `IPL_IDX_VBASE: next_st.vbase = vbase_wr[`IPL_VBASE_W-1:0];
                default: next_st.vbase = st.vbase;
            endcase
        end
        next_st.core_irq = found;
        if (!found)
        begin
            next_st.level_code = 2'b00;
        end
        else if (best_lvl == 2'b00)
        begin
            next_st.level_code = 2'b01;
        end
        else if (best_lvl == 2'b01)
        begin
            next_st.level_code = 2'b10;
        end
        else
        begin
            next_st.level_code = 2'b11;
        end
        next_st.vector = found ? {st.vbase, best_vec} : st.vector;
        // The snapshot is taken as the mode begins; sources enabled later cannot wake the core.
        next_st.lp_prev = low_power_i;
        if (low_power_i && !st.lp_prev)
        begin
            next_st.lp_snap = src_en;
        end
        next_st.wake = low_power_i && st.lp_prev && |(irq_req_i & st.lp_snap);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.prio <= {`IPL_NUM_PRIO{`IPL_RESET_PRIO}};
            st.vbase <= `IPL_RESET_VBASE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign wb_rsp_o.ack = st.ack;
    assign wb_rsp_o.dat = st.rdata;
    assign core_irq_o = st.core_irq;
    assign level_code_o = st.level_code;
    assign vector_o = st.vector;
    assign wake_o = st.wake;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_only_rx_full_lvl1;
        (irq_req_i & src_en) == 27'h000_0010 && st.prio[0][9:8] == 2'b01;
    endsequence
    sequence s_only_step_lvl3;
        (irq_req_i & src_en) == 27'h000_0001 && st.prio[0][1:0] == 2'b11;
    endsequence
    sequence s_only_port_d_lvl0;
        (irq_req_i & src_en) == 27'h000_0100 && st.prio[1][15:14] == 2'b01;
    endsequence
    sequence s_tie_break;
        (irq_req_i & src_en) == 27'h000_0110 && st.prio[0][9:8] == 2'b01 && st.prio[1][15:14] == 2'b10;
    endsequence
    sequence s_vec_stable;
        (irq_req_i & src_en) == 27'h010_0000 && !bus_wr;
    endsequence
    sequence s_in_low_power;
        low_power_i && st.lp_prev && |(irq_req_i & st.lp_snap);
    endsequence

    a_rx_full_level: assert property (s_only_rx_full_lvl1 |=> level_code_o == 2'b10 && vector_o[6:0] == 7'h04)
        else $error("receive-full source at code 01 not presented as level 1");
    a_step_level: assert property (s_only_step_lvl3 |=> core_irq_o && level_code_o == 2'b11)
        else $error("step source at code 11 not presented as level 3");
    a_port_d_level: assert property (s_only_port_d_lvl0 |=> level_code_o == 2'b01 && vector_o[6:0] == 7'h08)
        else $error("port D source at code 01 not presented as level 0");
    a_reserved_zero: assert property (st.ack |-> st.prio[1][13:6] == 8'h00 && st.prio[3][13:6] == 8'h00
                                               && st.prio[2][13:10] == 4'h0 && st.prio[0][15:10] == 6'h00)
        else $error("reserved priority bits became nonzero");
    a_reset_clear: assert property ($fell(rst_i) |-> st.prio == '0 && !core_irq_o && !wake_o)
        else $error("priority fields not cleared by reset");
    a_vector_form: assert property (s_vec_stable |=> vector_o == {$past(st.vbase), 7'h14})
        else $error("vector is not base joined with vector number");
    a_level_none: assert property ((irq_req_i & src_en) == '0 |=> !core_irq_o && level_code_o == 2'b00)
        else $error("request presented with no enabled pending source");
    a_tie_winner: assert property (s_tie_break |=> vector_o[6:0] == 7'h04 && level_code_o == 2'b10)
        else $error("equal levels not resolved toward lower vector number");
    a_wake_raise: assert property (s_in_low_power |=> wake_o)
        else $error("wake not raised for source enabled before low power");
    a_wake_quiet: assert property (!low_power_i |=> !wake_o ##1 !wake_o || low_power_i)
        else $error("wake raised outside low-power mode");
    a_bus_ack: assert property (bus_req |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("bus answer not exactly one cycle long");
    sequence s_alone_tx_empty;
        (irq_req_i & src_en) == 27'h000_0008;
    endsequence
    a_tx_empty_level: assert property (s_alone_tx_empty |=>
        level_code_o == (($past(st.prio[0][7:6]) == 2'b01) ? 2'b10 : 2'b11) && vector_o[6:0] == 7'h03)
        else $error("debug transmit-empty source presented at wrong level");
    sequence s_alone_trace;
        (irq_req_i & src_en) == 27'h000_0004;
    endsequence
    a_trace_level: assert property (s_alone_trace |=>
        level_code_o == (($past(st.prio[0][5:4]) == 2'b01) ? 2'b10 : 2'b11) && vector_o[6:0] == 7'h02)
        else $error("trace source presented at wrong level");
    sequence s_alone_breakpoint;
        (irq_req_i & src_en) == 27'h000_0002;
    endsequence
    a_breakpoint_level: assert property (s_alone_breakpoint |=>
        level_code_o == (($past(st.prio[0][3:2]) == 2'b01) ? 2'b10 : 2'b11) && vector_o[6:0] == 7'h01)
        else $error("breakpoint source presented at wrong level");
    sequence s_alone_flash_buf;
        (irq_req_i & src_en) == 27'h000_0080;
    endsequence
    a_flash_buf_level: assert property (s_alone_flash_buf |=>
        level_code_o == $past(st.prio[1][5:4]) && vector_o[6:0] == 7'h07)
        else $error("flash buffers-empty source presented at wrong level");
    sequence s_alone_flash_done;
        (irq_req_i & src_en) == 27'h000_0040;
    endsequence
    a_flash_done_level: assert property (s_alone_flash_done |=>
        level_code_o == $past(st.prio[1][3:2]) && vector_o[6:0] == 7'h06)
        else $error("flash command-done source presented at wrong level");
    sequence s_alone_flash_err;
        (irq_req_i & src_en) == 27'h000_0020;
    endsequence
    a_flash_err_level: assert property (s_alone_flash_err |=>
        level_code_o == $past(st.prio[1][1:0]) && vector_o[6:0] == 7'h05)
        else $error("flash error source presented at wrong level");
    sequence s_alone_ser_tx;
        (irq_req_i & src_en) == 27'h000_4000;
    endsequence
    a_ser_tx_level: assert property (s_alone_ser_tx |=>
        level_code_o == $past(st.prio[2][15:14]) && vector_o[6:0] == 7'h0e)
        else $error("serial transmit-empty source presented at wrong level");
    sequence s_alone_sync_tx;
        (irq_req_i & src_en) == 27'h000_2000;
    endsequence
    a_sync_tx_level: assert property (s_alone_sync_tx |=>
        level_code_o == $past(st.prio[2][9:8]) && vector_o[6:0] == 7'h0d)
        else $error("sync serial transmit source presented at wrong level");
    sequence s_alone_sync_rx;
        (irq_req_i & src_en) == 27'h000_1000;
    endsequence
    a_sync_rx_level: assert property (s_alone_sync_rx |=>
        level_code_o == $past(st.prio[2][7:6]) && vector_o[6:0] == 7'h0c)
        else $error("sync serial receive source presented at wrong level");
    sequence s_alone_port_a;
        (irq_req_i & src_en) == 27'h000_0800;
    endsequence
    a_port_a_level: assert property (s_alone_port_a |=>
        level_code_o == $past(st.prio[2][5:4]) && vector_o[6:0] == 7'h0b)
        else $error("port A source presented at wrong level");
    sequence s_alone_port_b;
        (irq_req_i & src_en) == 27'h000_0400;
    endsequence
    a_port_b_level: assert property (s_alone_port_b |=>
        level_code_o == $past(st.prio[2][3:2]) && vector_o[6:0] == 7'h0a)
        else $error("port B source presented at wrong level");
    sequence s_alone_port_c;
        (irq_req_i & src_en) == 27'h000_0200;
    endsequence
    a_port_c_level: assert property (s_alone_port_c |=>
        level_code_o == $past(st.prio[2][1:0]) && vector_o[6:0] == 7'h09)
        else $error("port C source presented at wrong level");
    sequence s_alone_tw_err;
        (irq_req_i & src_en) == 27'h004_0000;
    endsequence
    a_tw_err_level: assert property (s_alone_tw_err |=>
        level_code_o == $past(st.prio[3][15:14]) && vector_o[6:0] == 7'h12)
        else $error("two-wire error source presented at wrong level");
    sequence s_alone_ser_rx;
        (irq_req_i & src_en) == 27'h002_0000;
    endsequence
    a_ser_rx_level: assert property (s_alone_ser_rx |=>
        level_code_o == $past(st.prio[3][5:4]) && vector_o[6:0] == 7'h11)
        else $error("serial receive-full source presented at wrong level");
    sequence s_alone_ser_rerr;
        (irq_req_i & src_en) == 27'h001_0000;
    endsequence
    a_ser_rerr_level: assert property (s_alone_ser_rerr |=>
        level_code_o == $past(st.prio[3][3:2]) && vector_o[6:0] == 7'h10)
        else $error("serial receive-error source presented at wrong level");
    sequence s_alone_ser_idle;
        (irq_req_i & src_en) == 27'h000_8000;
    endsequence
    a_ser_idle_level: assert property (s_alone_ser_idle |=>
        level_code_o == $past(st.prio[3][1:0]) && vector_o[6:0] == 7'h0f)
        else $error("serial transmit-idle source presented at wrong level");
    sequence s_alone_gen_call;
        (irq_req_i & src_en) == 27'h008_0000;
    endsequence
    a_gen_call_level: assert property (s_alone_gen_call |=>
        level_code_o == $past(st.prio[4][1:0]) && vector_o[6:0] == 7'h13)
        else $error("general call source presented at wrong level");
    sequence s_alone_timer3;
        (irq_req_i & src_en) == 27'h400_0000;
    endsequence
    a_timer3_level: assert property (s_alone_timer3 |=>
        level_code_o == $past(st.prio[4][15:14]) && vector_o[6:0] == 7'h1a)
        else $error("timer channel 3 source presented at wrong level");

endmodule : ipl_ctrl

// ---- tb/ipl_core_model.sv ----
// Purpose: Behavioural model of the processor core that takes prioritised requests.
// Assumes: Request, level code and vector are registered outputs of the controller.
// Notes: The core has no handshake back, so it only records what it was offered.

module ipl_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic core_irq_i,
    input wire logic [1:0] level_code_i,
    input wire logic [15:0] vector_i,
    output logic [1:0] taken_level_o,
    output logic [15:0] taken_vector_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Capture of the offered request
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            taken_level_o <= 2'h0;
            taken_vector_o <= 16'h0000;
        end
        else if (core_irq_i)
        begin
            taken_level_o <= level_code_i;
            taken_vector_o <= vector_i;
        end
    end
endmodule : ipl_core_model

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the priority-level block over Wishbone.
// Assumes: Answers come one cycle after a request; outputs lag the inputs by one cycle.
// Notes: All sources are held pending in the decode sweep, so any disabled source that leaks shows up.

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ipl_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    ipl_wb_req_s wb_req = '0;
    ipl_wb_rsp_s wb_rsp;
    logic [26:0] irq_req = '0;
    logic low_power = 1'b0;
    logic core_irq;
    logic [1:0] level_code;
    logic [15:0] vector;
    logic wake;
    logic [1:0] taken_level;
    logic [15:0] taken_vector;
    logic [31:0] rd;
    logic [15:0] shadow [0:4];
    logic [15:0] wmask [0:4] = '{16'h03ff, 16'hc03f, 16'hc3ff, 16'hc03f, 16'hffff};
    int n_fail = 0;
    int n_tests = 0;

    always #12.5 clk_i = ~clk_i;

    ipl_ctrl ipl_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .irq_req_i(irq_req), .low_power_i(low_power), .core_irq_o(core_irq),
        .level_code_o(level_code), .vector_o(vector), .wake_o(wake));

    ipl_core_model ipl_core_model_i (.clk_i(clk_i), .rst_i(rst_i), .core_irq_i(core_irq),
        .level_code_i(level_code), .vector_i(vector), .taken_level_o(taken_level),
        .taken_vector_o(taken_vector));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] wdat, input logic [3:0] sel);
        int k;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: {idx, 2'b00}, dat: wdat};
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_i);
            if (wb_rsp.ack === 1'b1)
            begin
                break;
            end
        end
        if (k == 20)
        begin
            n_fail++;
            conclude();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb

    // Bit offset of a source's field, counted as register * 16 + low bit.
    function automatic int loc(input int s);
        if (s < 5) return s * 2;
        if (s < 8) return 16 + (s - 5) * 2;
        if (s == 8) return 30;
        if (s < 14) return 32 + (s - 9) * 2;
        if (s == 14) return 46;
        if (s < 18) return 48 + (s - 15) * 2;
        if (s == 18) return 62;
        return 64 + (s - 19) * 2;
    endfunction : loc

    // Debug sources start at level 1, all others at level 0.
    function automatic logic [1:0] lcode(input int s, input int c);
        int lvl;
        lvl = (s < 5) ? c : c - 1;
        return (lvl >= 2) ? 2'b11 : 2'(lvl + 1);
    endfunction : lcode

    task automatic set_src(input int s, input logic [1:0] c);
        int p;
        p = loc(s);
        shadow[p / 16][p % 16 +: 2] = c;
        wb(1'b1, 6'(p / 16), {16'h0000, shadow[p / 16]}, 4'h3);
    endtask : set_src

    task automatic clr_all();
        for (int i = 0; i < 5; i++)
        begin
            shadow[i] = 16'h0000;
            wb(1'b1, 6'(i), 32'h0, 4'h3);
        end
    endtask : clr_all

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        int s;
        int c;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (s = 0; s < 5; s++)
        begin
            wb(1'b0, 6'(s), 32'h0, 4'hf);
            chk(rd, 32'h0);
            wb(1'b1, 6'(s), 32'hffffffff, 4'h3);
            wb(1'b0, 6'(s), 32'h0, 4'hf);
            chk(rd, {16'h0000, wmask[s]});
        end
        clr_all();
        wb(1'b1, 6'h04, 32'h0000a5a5, 4'h1);
        wb(1'b0, 6'h04, 32'h0, 4'hf);
        chk(rd, 32'h000000a5);
        wb(1'b1, 6'h05, 32'hffffffff, 4'h3);
        wb(1'b0, 6'h05, 32'h0, 4'hf);
        chk(rd, 32'h0);
        clr_all();
        wb(1'b1, 6'h07, 32'h000001a5, 4'h3);
        wb(1'b0, 6'h07, 32'h0, 4'hf);
        chk(rd, 32'h000001a5);
        // Every source pending at once; only the one under test has a level.
        irq_req <= '1;
        for (s = 0; s < 27; s++)
        begin
            for (c = 0; c < 4; c++)
            begin
                set_src(s, 2'(c));
                repeat (3) @(posedge clk_i);
                chk(core_irq, 32'(c != 0));
                if (c != 0)
                begin
                    chk(level_code, lcode(s, c));
                    chk(vector, {9'h1a5, 7'(s)});
                end
            end
            set_src(s, 2'h0);
        end
        // Arbitration: a tie, a higher level, then a debug level 3.
        irq_req <= 27'h0000111;
        set_src(4, 2'h1);
        set_src(8, 2'h2);
        repeat (3) @(posedge clk_i);
        chk(vector, {9'h1a5, 7'h04});
        chk(level_code, 2'b10);
        set_src(8, 2'h3);
        repeat (3) @(posedge clk_i);
        chk(vector, {9'h1a5, 7'h08});
        set_src(0, 2'h3);
        repeat (3) @(posedge clk_i);
        chk(level_code, 2'b11);
        chk(taken_vector, {9'h1a5, 7'h00});
        chk(taken_level, 2'b11);
        wb(1'b0, 6'h16, 32'h0, 4'hf);
        chk(rd, 32'h00000007);
        irq_req <= '0;
        repeat (3) @(posedge clk_i);
        chk(core_irq, 32'h0);
        // Low power: only a source enabled before entry may wake.
        clr_all();
        set_src(9, 2'h1);
        low_power <= 1'b1;
        repeat (3) @(posedge clk_i);
        set_src(10, 2'h1);
        irq_req <= 27'h0000400;
        repeat (4) @(posedge clk_i);
        chk(wake, 32'h0);
        irq_req <= 27'h0000200;
        for (c = 0; c < 10 && wake !== 1'b1; c++)
        begin
            @(posedge clk_i);
        end
        chk(wake, 32'h1);
        low_power <= 1'b0;
        irq_req <= '0;
        repeat (3) @(posedge clk_i);
        chk(wake, 32'h0);
        conclude();
    end
endmodule : tb
